//--- rtl/rca_pkg.sv
`default_nettype none
package rca_pkg;
  // Register byte offsets
  localparam logic [7:0] RCA_OFS_WEEKDAY = 8'h00;
  localparam logic [7:0] RCA_OFS_DAY = 8'h04;
  localparam logic [7:0] RCA_OFS_MONTH = 8'h08;
  localparam logic [7:0] RCA_OFS_YEAR = 8'h0c;
  localparam logic [7:0] RCA_OFS_SEC_ALARM = 8'h10;
  localparam logic [7:0] RCA_OFS_MIN_ALARM = 8'h14;
  localparam logic [7:0] RCA_OFS_HOUR_ALARM = 8'h18;
  localparam logic [7:0] RCA_OFS_CONTROL = 8'h1c;
  // Word index width and end of the mapped byte range
  localparam int RCA_IDX_W = 3;
  localparam logic [7:0] RCA_MAP_END = 8'h20;
  // Control register fields
  localparam int RCA_CTL_CF_BIT = 7;
  localparam int RCA_CTL_AIE_BIT = 3;
  localparam int RCA_CTL_AF_BIT = 0;
  // Alarm enable field
  localparam int RCA_ALARM_EN_BIT = 7;
  // Calendar limits (BCD)
  localparam logic [2:0] RCA_WEEKDAY_FIRST = 3'h0;
  localparam logic [2:0] RCA_WEEKDAY_LAST = 3'h6;
  localparam logic [5:0] RCA_DAY_FIRST = 6'h01;
  localparam logic [5:0] RCA_DAY_31 = 6'h31;
  localparam logic [5:0] RCA_DAY_30 = 6'h30;
  localparam logic [5:0] RCA_DAY_29 = 6'h29;
  localparam logic [5:0] RCA_DAY_28 = 6'h28;
  localparam logic [4:0] RCA_MONTH_FIRST = 5'h01;
  localparam logic [4:0] RCA_MONTH_FEB = 5'h02;
  localparam logic [4:0] RCA_MONTH_LAST = 5'h12;
  localparam logic [15:0] RCA_YEAR_LAST = 16'h9999;
  localparam logic [3:0] RCA_BCD_NINE = 4'h9;
  // Values after reset
  localparam logic RCA_RST_ALARM_EN = 1'b0;
  localparam logic RCA_RST_FLAG = 1'b0;
  localparam logic RCA_RST_AIE = 1'b0;
  // AXI responses
  localparam logic [1:0] RCA_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCA_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- rtl/rca_last_day.sv
`timescale 1ns/100ps
`default_nettype none
module rca_last_day import rca_pkg::*; (
  input wire logic [4:0] i_month, // BCD month
  input wire logic [15:0] i_year, // BCD year
  output logic [5:0] o_last_day, // BCD last day of month
  output logic o_leap // Year is leap
);
  logic div4_low;
  logic div4_high;
  logic low_zero;
  logic is_long;

  // Two BCD digits divisible by four
  function automatic logic bcd_div4(input logic [3:0] tens, input logic [3:0] units);
    logic u_even;
    u_even = (units == 4'h0) || (units == 4'h4) || (units == 4'h8);
    bcd_div4 = tens[0] ? ((units == 4'h2) || (units == 4'h6)) : u_even;
  endfunction

  // Leap year from divisibility by 4, 100 and 400
  assign div4_low = bcd_div4(i_year[7:4], i_year[3:0]);
  assign div4_high = bcd_div4(i_year[15:12], i_year[11:8]);
  assign low_zero = (i_year[7:0] == 8'h00);
  assign o_leap = low_zero ? div4_high : div4_low;

  // Months with 31 days
  assign is_long = (i_month == 5'h01) || (i_month == 5'h03) || (i_month == 5'h05) ||
                   (i_month == 5'h07) || (i_month == 5'h08) || (i_month == 5'h10) ||
                   (i_month == RCA_MONTH_LAST);
  assign o_last_day = (i_month == RCA_MONTH_FEB) ? (o_leap ? RCA_DAY_29 : RCA_DAY_28) :
                      (is_long ? RCA_DAY_31 : RCA_DAY_30);
endmodule // rca_last_day
`default_nettype wire

//--- rtl/rca_calendar_alarm.sv
`timescale 1ns/100ps
`default_nettype none
module rca_calendar_alarm import rca_pkg::*; (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_day_carry, // Daily carry pulse from hour stage
  input wire logic i_sec_carry, // Second counter carry pulse
  input wire logic i_div_carry, // Divider carry pulse
  input wire logic i_fast_read, // Fast counter being read
  input wire logic [7:0] i_second_count, // BCD second counter
  input wire logic [7:0] i_minute_count, // BCD minute counter
  input wire logic [7:0] i_hour_count, // BCD hour counter
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic o_alarm_flag, // Alarm flag
  output logic o_carry_flag, // Carry flag
  output logic o_alarm_irq // Alarm interrupt
);
  // Reset synchroniser
  logic rst_meta_n_ff;
  logic rst_n_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_n_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_n_ff <= 1'b1;
      rst_n_ff <= rst_meta_n_ff;
    end
  end

  // Calendar and alarm storage
  logic [2:0] weekday_ff;
  logic [5:0] day_ff;
  logic [4:0] month_ff;
  logic [15:0] year_ff;
  logic [6:0] sec_alarm_ff, min_alarm_ff;
  logic [5:0] hour_alarm_ff;
  logic sec_alarm_en_ff, min_alarm_en_ff, hour_alarm_en_ff;
  logic alarm_flag_ff, carry_flag_ff, alarm_irq_en_ff, match_prev_ff;

  // Bus state
  logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  // Write channel handshakes and decode
  logic aw_fire, w_fire, wr_fire, wr_mapped, wr_lane0, wr_lane1;
  logic [RCA_IDX_W-1:0] wr_idx;
  logic wr_weekday, wr_day, wr_month, wr_year_lo, wr_year_hi;
  logic wr_sec_alarm, wr_min_alarm, wr_hour_alarm, wr_control;

  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_mapped = (aw_addr_ff < RCA_MAP_END);
  assign wr_idx = aw_addr_ff[RCA_IDX_W+1:2];
  assign wr_lane0 = wr_fire && wr_mapped && w_strb_ff[0];
  assign wr_lane1 = wr_fire && wr_mapped && w_strb_ff[1];
  assign wr_weekday = wr_lane0 && (wr_idx == RCA_OFS_WEEKDAY[RCA_IDX_W+1:2]);
  assign wr_day = wr_lane0 && (wr_idx == RCA_OFS_DAY[RCA_IDX_W+1:2]);
  assign wr_month = wr_lane0 && (wr_idx == RCA_OFS_MONTH[RCA_IDX_W+1:2]);
  assign wr_year_lo = wr_lane0 && (wr_idx == RCA_OFS_YEAR[RCA_IDX_W+1:2]);
  assign wr_year_hi = wr_lane1 && (wr_idx == RCA_OFS_YEAR[RCA_IDX_W+1:2]);
  assign wr_sec_alarm = wr_lane0 && (wr_idx == RCA_OFS_SEC_ALARM[RCA_IDX_W+1:2]);
  assign wr_min_alarm = wr_lane0 && (wr_idx == RCA_OFS_MIN_ALARM[RCA_IDX_W+1:2]);
  assign wr_hour_alarm = wr_lane0 && (wr_idx == RCA_OFS_HOUR_ALARM[RCA_IDX_W+1:2]);
  assign wr_control = wr_lane0 && (wr_idx == RCA_OFS_CONTROL[RCA_IDX_W+1:2]);

  // Write address and data holding
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (w_fire) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RCA_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_mapped ? RCA_RESP_OKAY : RCA_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Next calendar values
  logic [5:0] last_day;
  logic leap_year;
  logic day_wrap;
  logic month_carry;
  logic month_wrap;
  logic year_carry;
  logic [2:0] nxt_weekday;
  logic [5:0] nxt_day;
  logic [4:0] nxt_month;
  logic [15:0] nxt_year;
  logic [4:0] yr_cin;

  rca_last_day u_last_day (
    .i_month(month_ff),
    .i_year(year_ff),
    .o_last_day(last_day),
    .o_leap(leap_year)
  );

  // Weekday wraps Saturday to Sunday
  assign nxt_weekday = (weekday_ff >= RCA_WEEKDAY_LAST) ? RCA_WEEKDAY_FIRST :
                       weekday_ff + 3'h1;

  // Day steps in BCD and wraps past the month's last day
  assign day_wrap = (day_ff >= last_day);
  assign nxt_day = day_wrap ? RCA_DAY_FIRST :
                   (day_ff[3:0] == RCA_BCD_NINE) ? {day_ff[5:4] + 2'h1, 4'h0} :
                   {day_ff[5:4], day_ff[3:0] + 4'h1};
  assign month_carry = i_day_carry && day_wrap;

  // Month steps in BCD and wraps past December
  assign month_wrap = (month_ff >= RCA_MONTH_LAST);
  assign nxt_month = month_wrap ? RCA_MONTH_FIRST :
                     (month_ff[3:0] == RCA_BCD_NINE) ? 5'h10 :
                     {month_ff[4], month_ff[3:0] + 4'h1};
  assign year_carry = month_carry && month_wrap;

  // Year digits ripple in BCD, 9999 wraps to 0000
  assign yr_cin[0] = 1'b1;
  for (genvar g = 0; g < 4; g++) begin : g_year_digit
    assign nxt_year[4*g+:4] = !yr_cin[g] ? year_ff[4*g+:4] :
                              (year_ff[4*g+:4] == RCA_BCD_NINE) ? 4'h0 :
                              year_ff[4*g+:4] + 4'h1;
    assign yr_cin[g+1] = yr_cin[g] && (year_ff[4*g+:4] == RCA_BCD_NINE);
  end

  // Calendar counters, no reset so contents survive it; writes beat carries
  always_ff @(posedge i_clk) begin
    if (wr_weekday) begin
      weekday_ff <= w_data_ff[2:0];
    end else if (i_day_carry) begin
      weekday_ff <= nxt_weekday;
    end
    if (wr_day) begin
      day_ff <= w_data_ff[5:0];
    end else if (i_day_carry) begin
      day_ff <= nxt_day;
    end
    if (wr_month) begin
      month_ff <= w_data_ff[4:0];
    end else if (month_carry) begin
      month_ff <= nxt_month;
    end
    if (wr_year_lo || wr_year_hi) begin
      year_ff <= {wr_year_hi ? w_data_ff[15:8] : year_ff[15:8],
                  wr_year_lo ? w_data_ff[7:0] : year_ff[7:0]};
    end else if (year_carry) begin
      year_ff <= nxt_year;
    end
  end

  // Alarm fields, kept through reset
  always_ff @(posedge i_clk) begin
    if (wr_sec_alarm) begin
      sec_alarm_ff <= w_data_ff[6:0];
    end
    if (wr_min_alarm) begin
      min_alarm_ff <= w_data_ff[6:0];
    end
    if (wr_hour_alarm) begin
      hour_alarm_ff <= w_data_ff[5:0];
    end
  end

  // Alarm enables, cleared by reset
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sec_alarm_en_ff <= RCA_RST_ALARM_EN;
      min_alarm_en_ff <= RCA_RST_ALARM_EN;
      hour_alarm_en_ff <= RCA_RST_ALARM_EN;
    end else begin
      if (wr_sec_alarm) begin
        sec_alarm_en_ff <= w_data_ff[RCA_ALARM_EN_BIT];
      end
      if (wr_min_alarm) begin
        min_alarm_en_ff <= w_data_ff[RCA_ALARM_EN_BIT];
      end
      if (wr_hour_alarm) begin
        hour_alarm_en_ff <= w_data_ff[RCA_ALARM_EN_BIT];
      end
    end
  end

  // Alarm comparison over enabled fields only
  logic any_alarm_en;
  logic alarm_match;
  logic alarm_set;
  logic carry_set;

  assign any_alarm_en = sec_alarm_en_ff || min_alarm_en_ff || hour_alarm_en_ff;
  assign alarm_match = any_alarm_en &&
                       (!sec_alarm_en_ff || (sec_alarm_ff == i_second_count[6:0])) &&
                       (!min_alarm_en_ff || (min_alarm_ff == i_minute_count[6:0])) &&
                       (!hour_alarm_en_ff || (hour_alarm_ff == i_hour_count[5:0]));
  assign alarm_set = alarm_match && !match_prev_ff;
  assign carry_set = i_sec_carry || (i_div_carry && i_fast_read);

  // Flags: hardware set wins over a software clear
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      alarm_flag_ff <= RCA_RST_FLAG;
      carry_flag_ff <= RCA_RST_FLAG;
      alarm_irq_en_ff <= RCA_RST_AIE;
      match_prev_ff <= 1'b0;
    end else begin
      match_prev_ff <= alarm_match;
      alarm_flag_ff <= alarm_set ||
                       (wr_control ? (w_data_ff[RCA_CTL_AF_BIT] && alarm_flag_ff) :
                       alarm_flag_ff);
      carry_flag_ff <= carry_set ||
                       (wr_control ? w_data_ff[RCA_CTL_CF_BIT] : carry_flag_ff);
      if (wr_control) begin
        alarm_irq_en_ff <= w_data_ff[RCA_CTL_AIE_BIT];
      end
    end
  end

  assign o_alarm_flag = alarm_flag_ff;
  assign o_carry_flag = carry_flag_ff;
  assign o_alarm_irq = alarm_flag_ff && alarm_irq_en_ff;

  // Read decode, reserved bits as zero
  logic ar_fire;
  logic rd_mapped;
  logic [RCA_IDX_W-1:0] rd_idx;
  logic [31:0] rd_word;
  logic [31:0] ctl_word;

  assign s_axi_arready = !rvalid_ff;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign rd_mapped = (s_axi_araddr < RCA_MAP_END);
  assign rd_idx = s_axi_araddr[RCA_IDX_W+1:2];
  assign ctl_word = {24'h00_0000, carry_flag_ff, 3'h0, alarm_irq_en_ff, 2'h0, alarm_flag_ff};
  assign rd_word = !rd_mapped ? 32'h0000_0000 :
    (rd_idx == RCA_OFS_WEEKDAY[RCA_IDX_W+1:2]) ? {29'h0000_0000, weekday_ff} :
    (rd_idx == RCA_OFS_DAY[RCA_IDX_W+1:2]) ? {26'h000_0000, day_ff} :
    (rd_idx == RCA_OFS_MONTH[RCA_IDX_W+1:2]) ? {27'h000_0000, month_ff} :
    (rd_idx == RCA_OFS_YEAR[RCA_IDX_W+1:2]) ? {16'h0000, year_ff} :
    (rd_idx == RCA_OFS_SEC_ALARM[RCA_IDX_W+1:2]) ?
      {24'h00_0000, sec_alarm_en_ff, sec_alarm_ff} :
    (rd_idx == RCA_OFS_MIN_ALARM[RCA_IDX_W+1:2]) ?
      {24'h00_0000, min_alarm_en_ff, min_alarm_ff} :
    (rd_idx == RCA_OFS_HOUR_ALARM[RCA_IDX_W+1:2]) ?
      {24'h00_0000, hour_alarm_en_ff, 1'b0, hour_alarm_ff} :
    ctl_word;

  // Read response
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RCA_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_mapped ? RCA_RESP_OKAY : RCA_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Checks
  chk_weekday_wrap: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (i_day_carry && !wr_weekday && weekday_ff == RCA_WEEKDAY_LAST) |=>
      weekday_ff == RCA_WEEKDAY_FIRST)
    else $error("weekday did not wrap to Sunday");
  chk_weekday_zero: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (ar_fire && s_axi_araddr == RCA_OFS_WEEKDAY) |=> s_axi_rdata[31:3] == 29'h0000_0000)
    else $error("weekday upper bits not zero");
  chk_day_step: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (i_day_carry && !wr_day && !day_wrap && day_ff[3:0] == RCA_BCD_NINE) |=>
      day_ff[3:0] == 4'h0 && day_ff[5:4] == $past(day_ff[5:4]) + 2'h1)
    else $error("day BCD step wrong");
  chk_leap_feb: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (i_day_carry && !wr_day && month_ff == RCA_MONTH_FEB && day_ff == RCA_DAY_28 &&
     leap_year) |=> day_ff == RCA_DAY_29)
    else $error("leap February skipped day 29");
  chk_day_wrap: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (i_day_carry && !wr_day && !wr_month && day_ff == last_day) |=>
      day_ff == RCA_DAY_FIRST && month_ff != $past(month_ff))
    else $error("month end did not wrap day and carry");
  chk_day_zero: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (ar_fire && s_axi_araddr == RCA_OFS_DAY) |=> s_axi_rdata[31:6] == 26'h000_0000)
    else $error("day upper bits not zero");
  chk_month_wrap: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (month_carry && !wr_month && month_ff == RCA_MONTH_LAST) |=>
      month_ff == RCA_MONTH_FIRST)
    else $error("month did not wrap to January");
  chk_month_zero: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (ar_fire && s_axi_araddr == RCA_OFS_MONTH) |=> s_axi_rdata[31:5] == 27'h000_0000)
    else $error("month upper bits not zero");
  chk_year_carry: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (year_carry && !wr_year_lo && !wr_year_hi) |=> year_ff != $past(year_ff))
    else $error("yearly carry lost");
  chk_year_wrap: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (year_carry && !wr_year_lo && !wr_year_hi && year_ff == RCA_YEAR_LAST) |=>
      year_ff == 16'h0000)
    else $error("year did not wrap to 0000");
  chk_alarm_set: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (alarm_match && !match_prev_ff) |=> alarm_flag_ff ##1 !alarm_match || alarm_flag_ff)
    else $error("alarm flag not set on match");
  chk_alarm_idle: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (!any_alarm_en && !alarm_flag_ff && !wr_control) |=> !alarm_flag_ff)
    else $error("alarm flag set with no field enabled");
  chk_carry_set: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (i_div_carry && i_fast_read) |=> o_carry_flag)
    else $error("carry flag not set");
  chk_irq_gate: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    (wr_control && !w_data_ff[RCA_CTL_AIE_BIT]) |=> !o_alarm_irq)
    else $error("alarm interrupt not masked by cleared enable");
endmodule // rca_calendar_alarm
`default_nettype wire

//--- bench/rca_calendar_alarm_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rca_calendar_alarm_bench import rca_pkg::*; ;
  // Stimulus and observed signals
  logic clk = 0, rst_n = 0, dcar = 0, scar = 0, dvcar = 0, fread = 0, awv = 0, wv = 0, arv = 0;
  logic [7:0] sc = 0, mc = 0, hc = 0, awa = 0, ara = 0;
  logic [3:0] ws = 4'hf;
  logic [31:0] wd = 0, rd;
  logic [1:0] resp;
  wire awr, wrd, bv, arr, rv, af, cf, irq;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  int bad_count = 0, tests_run = 0, cyc = 0, ey = 0;
  rca_calendar_alarm uut (.i_clk(clk), .i_rst_n(rst_n), .i_day_carry(dcar), .i_sec_carry(scar),
    .i_div_carry(dvcar), .i_fast_read(fread), .i_second_count(sc), .i_minute_count(mc),
    .i_hour_count(hc), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .o_alarm_flag(af), .o_carry_flag(cf),
    .o_alarm_irq(irq));
  // Clock
  always #5 clk = ~clk;
  // Verdict and end of run
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      close_out();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus write: address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 0;
    dd = 0;
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    forever begin
      @(posedge clk);
      if (awr && !ad) begin ad = 1; awv <= 0; end
      if (wrd && !dd) begin dd = 1; wv <= 0; end
      if (bv) begin resp = br; break; end
    end
  endtask
  // Bus read
  task rdr(input logic [7:0] a);
    logic ad;
    ad = 0;
    ara <= a;
    arv <= 1;
    forever begin
      @(posedge clk);
      if (arr && !ad) begin ad = 1; arv <= 0; end
      if (rv) begin rd = rdat; resp = rr; break; end
    end
  endtask
  // Calendar arithmetic of the bench
  function automatic logic [15:0] i2b(int v);
    return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction
  function automatic int lastd(int m, int y);
    if (m == 2) return ((y % 400 == 0) || (y % 4 == 0 && y % 100 != 0)) ? 29 : 28;
    if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
    return 31;
  endfunction
  // Load a date, apply one daily carry, read the result back
  task cal(input int wk, input int d, input int m, input int y);
    int nd, nm;
    nd = d + 1;
    nm = m;
    ey = y;
    if (d == lastd(m, y)) begin
      nd = 1;
      nm = m % 12 + 1;
      if (m == 12) ey = (y + 1) % 10000;
    end
    wr(RCA_OFS_WEEKDAY, 32'(wk));
    wr(RCA_OFS_DAY, 32'(i2b(d)));
    wr(RCA_OFS_MONTH, 32'(i2b(m)));
    wr(RCA_OFS_YEAR, 32'(i2b(y)));
    dcar <= 1;
    @(posedge clk);
    dcar <= 0;
    rdr(RCA_OFS_WEEKDAY); chk("weekday", 32'((wk + 1) % 7), rd);
    rdr(RCA_OFS_DAY); chk("day", 32'(i2b(nd)), rd);
    rdr(RCA_OFS_MONTH); chk("month", 32'(i2b(nm)), rd);
    rdr(RCA_OFS_YEAR); chk("year", 32'(i2b(ey)), rd);
  endtask
  // Main sequence
  initial begin
    int m, y, d;
    void'($urandom(55781));
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rdr(RCA_OFS_CONTROL); chk("control", 32'h0000_0000, rd);
    rdr(RCA_OFS_SEC_ALARM); chk("sec enable", 32'h0000_0000, {31'h0, rd[7]});
    // Reserved bits written as ones, legal field values kept
    wr(RCA_OFS_WEEKDAY, 32'h0000_00fe);
    rdr(RCA_OFS_WEEKDAY);
    chk("wk bits", 32'h0000_0006, rd);
    wr(RCA_OFS_DAY, 32'h0000_00f1);
    rdr(RCA_OFS_DAY);
    chk("day bits", 32'h0000_0031, rd);
    wr(RCA_OFS_MONTH, 32'h0000_00f2);
    rdr(RCA_OFS_MONTH);
    chk("mon bits", 32'h0000_0012, rd);
    wr(RCA_OFS_HOUR_ALARM, 32'h0000_00d3);
    rdr(RCA_OFS_HOUR_ALARM);
    chk("hr bits", 32'h0000_0093, rd);
    wr(8'h20, 32'h0000_0001); chk("unmapped bresp", 32'(RCA_RESP_SLVERR), 32'(resp));
    rdr(8'h20); chk("unmapped rresp", 32'(RCA_RESP_SLVERR), 32'(resp));
    chk("unmapped data", 32'h0000_0000, rd);
    cal(6, 28, 2, 2000); cal(3, 28, 2, 1900); cal(2, 29, 2, 2024); cal(5, 31, 12, 9999);
    cal(0, 30, 4, 2023); cal(1, 31, 1, 2001); cal(4, 30, 9, 1999); cal(2, 19, 11, 2100);
    for (int i = 0; i < 24; i++) begin
      m = $urandom_range(1, 12);
      y = $urandom_range(0, 9999);
      d = $urandom_range(0, 1) ? lastd(m, y) : $urandom_range(1, lastd(m, y));
      cal($urandom_range(0, 6), d, m, y);
    end
    // Alarm: only the enabled second field takes part at first
    sc <= 8'h24; mc <= 8'h10; hc <= 8'h11;
    wr(RCA_OFS_SEC_ALARM, 32'h0000_00a5);
    wr(RCA_OFS_MIN_ALARM, 32'h0000_0033);
    wr(RCA_OFS_HOUR_ALARM, 32'h0000_0011);
    wr(RCA_OFS_CONTROL, 32'h0000_0008);
    chk("af idle", 32'h0, 32'(af));
    sc <= 8'h25; repeat (3) @(posedge clk);
    chk("af match", 32'h1, 32'(af));
    chk("irq on", 32'h1, 32'(irq));
    wr(RCA_OFS_CONTROL, 32'h0000_0000);
    sc <= 8'h24; @(posedge clk); sc <= 8'h25; repeat (3) @(posedge clk);
    chk("af again", 32'h1, 32'(af));
    chk("irq masked", 32'h0, 32'(irq));
    // Alarm: enabled hour field blocks until it matches
    wr(RCA_OFS_CONTROL, 32'h0000_0000);
    wr(RCA_OFS_HOUR_ALARM, 32'h0000_0092);
    sc <= 8'h24; @(posedge clk); sc <= 8'h25; repeat (3) @(posedge clk);
    chk("af hour miss", 32'h0, 32'(af));
    hc <= 8'h12; repeat (3) @(posedge clk);
    chk("af hour hit", 32'h1, 32'(af));
    // Carry flag sources and clearing
    wr(RCA_OFS_CONTROL, 32'h0000_0000);
    scar <= 1; @(posedge clk); scar <= 0; @(posedge clk);
    chk("cf sec", 32'h1, 32'(cf));
    wr(RCA_OFS_CONTROL, 32'h0000_0000); chk("cf clear", 32'h0, 32'(cf));
    dvcar <= 1; @(posedge clk); dvcar <= 0; @(posedge clk);
    chk("cf div idle", 32'h0, 32'(cf));
    dvcar <= 1; fread <= 1; @(posedge clk); dvcar <= 0; fread <= 0; @(posedge clk);
    chk("cf div read", 32'h1, 32'(cf));
    // Reset in mid-run keeps calendar and alarm fields
    rst_n <= 0; repeat (6) @(posedge clk); rst_n <= 1; repeat (3) @(posedge clk);
    rdr(RCA_OFS_SEC_ALARM); chk("sec after rst", 32'h0000_0025, rd);
    rdr(RCA_OFS_YEAR); chk("year after rst", 32'(i2b(ey)), rd);
    // Upper byte lane alone reaches the year's high digits
    ws <= 4'h2;
    wr(RCA_OFS_YEAR, 32'h0000_4321);
    ws <= 4'hf;
    rdr(RCA_OFS_YEAR);
    chk("year hi lane", {16'h0000, 8'h43, 4'(ey / 10 % 10), 4'(ey % 10)}, rd);
    close_out();
  end
endmodule // rca_calendar_alarm_bench
`default_nettype wire
